// ==== logic/smcg_mode_decode.v ====
`default_nettype none
// ----------------------------------------
// per-mode clock domain map
// ----------------------------------------
module smcg_mode_decode (
  // mode in
  input  wire [2:0] mode,
  // enables out
  output reg  [7:0] dom_en,
  output reg        osc_en,
  output reg        mode_ok
);
`include "smcg_regs.vh"
  // only six encodings name a sleep mode
  always @* begin
    dom_en  = 8'h00;
    osc_en  = 1'b0;
    mode_ok = 1'b1;
    case (mode)
      `SMCG_MODE_IDLE: begin
        dom_en = `SMCG_EN_ALL;
        dom_en[`SMCG_EN_CPU] = 1'b0;
        dom_en[`SMCG_EN_IO]  = 1'b0;
        dom_en[`SMCG_EN_ADC] = 1'b0;
        osc_en = 1'b1;
      end
      `SMCG_MODE_ADCNR: begin
        dom_en[`SMCG_EN_ADC]  = 1'b1;
        dom_en[`SMCG_EN_ATMR] = 1'b1;
        dom_en[`SMCG_EN_IRQ]  = 1'b1;
        osc_en = 1'b1;
      end
      `SMCG_MODE_PDOWN: begin
        dom_en[`SMCG_EN_IRQ] = 1'b1;
      end
      `SMCG_MODE_PSAVE: begin
        dom_en[`SMCG_EN_ATMR] = 1'b1;
        dom_en[`SMCG_EN_IRQ]  = 1'b1;
      end
      `SMCG_MODE_STBY: begin
        dom_en[`SMCG_EN_IRQ] = 1'b1;
        osc_en = 1'b1;
      end
      `SMCG_MODE_XSTBY: begin
        dom_en[`SMCG_EN_ATMR] = 1'b1;
        dom_en[`SMCG_EN_IRQ]  = 1'b1;
        osc_en = 1'b1;
      end
      default: begin
        dom_en  = `SMCG_EN_ALL;
        osc_en  = 1'b1;
        mode_ok = 1'b0;
      end
    endcase
  end
endmodule
`default_nettype wire

// ==== logic/smcg_regs.vh ====
`ifndef SMCG_REGS_VH
`define SMCG_REGS_VH
// ----------------------------------------
// sleep mode encodings
// ----------------------------------------
`define SMCG_MODE_W        3
`define SMCG_MODE_IDLE     3'h0
`define SMCG_MODE_ADCNR    3'h1
`define SMCG_MODE_PDOWN    3'h2
`define SMCG_MODE_PSAVE    3'h3
`define SMCG_MODE_STBY     3'h6
`define SMCG_MODE_XSTBY    3'h7
// ----------------------------------------
// clock enable vector bit positions
// ----------------------------------------
`define SMCG_EN_W          8
`define SMCG_EN_CPU        0
`define SMCG_EN_SRAM       1
`define SMCG_EN_TMR        2
`define SMCG_EN_SPI        3
`define SMCG_EN_IRQ        4
`define SMCG_EN_IO         5
`define SMCG_EN_ADC        6
`define SMCG_EN_ATMR       7
`define SMCG_EN_ALL        8'hFF
// ----------------------------------------
// controller states
// ----------------------------------------
`define SMCG_ST_RUN        2'h0
`define SMCG_ST_SLEEP      2'h1
`define SMCG_ST_WAKE       2'h2
`define SMCG_CNT_W         8
`define SMCG_WAKE_CYC      8'h04
`define SMCG_OSC_START_CYC 8'h40
`define SMCG_CNT_ZERO      8'h00
`define SMCG_CNT_ONE       8'h01
`define SMCG_EN_BIT        8'h01
`endif

// ==== logic/smcg_sleep_ctrl.v ====
`default_nettype none
`include "smcg_regs.vh"
// ----------------------------------------
// sleep controller
// ----------------------------------------
module smcg_sleep_ctrl #(
  // wake with oscillator running, in core clock cycles
  parameter WAKE_CYC      = `SMCG_WAKE_CYC,
  // oscillator start-up, in core clock cycles
  parameter OSC_START_CYC = `SMCG_OSC_START_CYC
) (
  // clock and reset
  input  wire       core_clk,
  input  wire       sys_rst,
  // processor side
  input  wire [2:0] mode_sel,
  input  wire       mode_wr,
  input  wire       sleep_en,
  input  wire       sleep_req,
  // wake sources
  input  wire       irq_wake,
  input  wire       hw_reset_wake,
  // clock domain enables
  output reg  [7:0] clk_en,
  output reg        osc_en,
  output reg        cpu_run,
  output reg        asleep,
  output reg  [2:0] mode_q
);
  // ----------------------------------------
  // state codes and counts
  // ----------------------------------------
  // binary codes; the unused fourth code falls back to run
  localparam [1:0] ST_RUN   = `SMCG_ST_RUN;
  localparam [1:0] ST_SLEEP = `SMCG_ST_SLEEP;
  localparam [1:0] ST_WAKE  = `SMCG_ST_WAKE;
  // wake lengths at counter width
  localparam [7:0] WAKE_N   = WAKE_CYC;
  localparam [7:0] OSC_N    = OSC_START_CYC;
  // ----------------------------------------
  // internal signals
  // ----------------------------------------
  // sequencer
  reg  [1:0] state_q;
  reg  [1:0] state_d;
  reg  [7:0] cnt_q;
  reg  [7:0] cnt_d;
  // mode latch
  reg  [2:0] mode_d;
  // next output values
  reg  [7:0] clk_en_d;
  reg        osc_en_d;
  reg        cpu_run_d;
  reg        asleep_d;
  // mode map results
  wire [7:0] map_en;
  wire       map_osc;
  wire       map_ok;
  // wake and entry terms
  wire       wake;
  wire       enter_ok;
  wire       wake_done;
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // wake length; a stopped oscillator needs its start-up time first
  function [7:0] wake_len;
    input osc_ran;
    begin
      if (osc_ran) begin
        wake_len = WAKE_N;
      end else begin
        wake_len = OSC_N;
      end
    end
  endfunction
  // every domain live but the cpu, which is let go last
  function [7:0] hold_cpu;
    input [7:0] en;
    begin
      hold_cpu = en & ~(`SMCG_EN_BIT << `SMCG_EN_CPU);
    end
  endfunction
  // ----------------------------------------
  // mode map
  // ----------------------------------------
  // decoded from the latched code, never from the live select lines
  // refused codes show every domain live and mode_ok low
  smcg_mode_decode smcg_mode_decode_i (
    .mode    (mode_q),
    .dom_en  (map_en),
    .osc_en  (map_osc),
    .mode_ok (map_ok)
  );
  // ----------------------------------------
  // wake and entry terms
  // ----------------------------------------
  // any wake source counts; reset also wakes from power-down
  assign wake = irq_wake | hw_reset_wake;
  // refused: sleep not allowed, code names no mode, code written in
  // the same cycle (map still shows the old one), wake already pending
  // trade: a write and a request together lose the request
  assign enter_ok = sleep_req & sleep_en & map_ok & ~mode_wr & ~wake;
  // one is the final count; zero only guards a lost load
  // limitation: a wake held high through the count is not seen again
  assign wake_done = (cnt_q <= `SMCG_CNT_ONE);
  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  // next state; unknown mode codes are refused so the cpu never hangs
  always @* begin
    state_d = state_q;
    cnt_d   = cnt_q;
    mode_d  = mode_q;
    case (state_q)
      ST_RUN: begin
        // a new code is only taken while running
        if (mode_wr) begin
          mode_d = mode_sel;
        end
        // sleep needs the code written at least a cycle earlier
        if (enter_ok) begin
          state_d = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        // mode and counter hold; the map stays as entered
        if (wake) begin
          state_d = ST_WAKE;
          // stopped oscillator needs start-up time, running one does not
          cnt_d   = wake_len(map_osc);
        end
      end
      ST_WAKE: begin
        // count down; wake sources are not looked at here
        if (wake_done) begin
          state_d = ST_RUN;
          cnt_d   = `SMCG_CNT_ZERO;
        end else begin
          cnt_d = cnt_q - `SMCG_CNT_ONE;
        end
      end
      default: begin
        // unused code; back to run with a clean counter
        state_d = ST_RUN;
        cnt_d   = `SMCG_CNT_ZERO;
      end
    endcase
  end
  // ----------------------------------------
  // state registers
  // ----------------------------------------
  // contents held through every mode
  // reset is asynchronous; its release is taken as clean to core_clk
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= `SMCG_ST_RUN;
      cnt_q   <= `SMCG_CNT_ZERO;
      mode_q  <= `SMCG_MODE_IDLE;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      mode_q  <= mode_d;
    end
  end
  // ----------------------------------------
  // next enables
  // ----------------------------------------
  // follow the next state, so enables and state move at one edge
  always @* begin
    clk_en_d  = `SMCG_EN_ALL;
    osc_en_d  = 1'b1;
    cpu_run_d = 1'b1;
    asleep_d  = 1'b0;
    case (state_d)
      ST_SLEEP: begin
        // asleep: the mode map decides
        // power-down leaves only the interrupt domain live
        clk_en_d  = map_en;
        osc_en_d  = map_osc;
        cpu_run_d = 1'b0;
        asleep_d  = 1'b1;
      end
      ST_WAKE: begin
        // oscillator and peripherals first, cpu once the count ends
        clk_en_d  = hold_cpu(`SMCG_EN_ALL);
        osc_en_d  = 1'b1;
        cpu_run_d = 1'b0;
      end
      default: begin
        // running: every domain restored
        clk_en_d  = `SMCG_EN_ALL;
        cpu_run_d = 1'b1;
      end
    endcase
  end
  // ----------------------------------------
  // enable registers
  // ----------------------------------------
  // registered so the clock gates never see a decode glitch
  // reset leaves everything running, cpu included
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      clk_en  <= `SMCG_EN_ALL;
      osc_en  <= 1'b1;
      cpu_run <= 1'b1;
      asleep  <= 1'b0;
    end else begin
      clk_en  <= clk_en_d;
      osc_en  <= osc_en_d;
      cpu_run <= cpu_run_d;
      asleep  <= asleep_d;
    end
  end
endmodule
`default_nettype wire

// ==== tb/smcg_chk_properties.sv ====
`default_nettype none
module smcg_chk (
  // watched ports
  input wire logic       core_clk,
  input wire logic       sys_rst,
  input wire logic       irq_wake,
  input wire logic [7:0] clk_en,
  input wire logic       osc_en,
  input wire logic       asleep,
  input wire logic [2:0] mode_q
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // one-hot of the mode slept in
  wire logic [7:0] s = asleep ? 8'h01 << mode_q : 8'h00;
  property p_idl; s[0] |-> clk_en[4:0] == 5'h1E; endproperty
  a_idl: assert property (p_idl) else $error("idle map");
  property p_adc; s[1] |-> (clk_en & 8'hE1) == 8'hC0; endproperty
  a_adc: assert property (p_adc) else $error("adc map");
  property p_pdn; s[2] |-> clk_en == 8'h10 && !osc_en; endproperty
  a_pdn: assert property (p_pdn) else $error("pdown map");
  property p_psv; s[3] |-> (clk_en & 8'h81) == 8'h80; endproperty
  a_psv: assert property (p_psv) else $error("psave map");
  property p_stb; s[6] |-> osc_en && !clk_en[0]; endproperty
  a_stb: assert property (p_stb) else $error("stby map");
  property p_xst; s[7] |-> osc_en && (clk_en & 8'h81) == 8'h80; endproperty
  a_xst: assert property (p_xst) else $error("xstby map");
  property p_lgl; asleep |-> mode_q[2:1] != 2'h2; endproperty
  a_lgl: assert property (p_lgl) else $error("bad mode");
  property p_wak; asleep && irq_wake |=> !asleep ##[1:70] (&clk_en); endproperty
  a_wak: assert property (p_wak) else $error("no wake");
  // main scenarios
  cover property (s[2]);
  cover property (s[7]);
  cover property (asleep && irq_wake);
endmodule
bind smcg_sleep_ctrl smcg_chk smcg_chk_i (
  .core_clk (core_clk),
  .sys_rst  (sys_rst),
  .irq_wake (irq_wake),
  .clk_en   (clk_en),
  .osc_en   (osc_en),
  .asleep   (asleep),
  .mode_q   (mode_q)
);
`default_nettype wire

// ==== tb/smcg_cpu_model.sv ====
`default_nettype none
module smcg_cpu_model (
  // command in, processor side out
  input  wire logic       core_clk,
  input  wire logic       go,
  input  wire logic       slow,
  input  wire logic [2:0] mode,
  output var  logic [2:0] mode_sel,
  output var  logic       mode_wr,
  output var  logic       sleep_req
);
  timeunit 1ns;
  timeprecision 1ns;
  logic dly_q = 1'b0;
  initial {mode_sel, mode_wr, sleep_req} = 5'h00;
  // select scrambled once written, so a late latch shows up
  always @(posedge core_clk) begin
    mode_sel  <= go ? mode : ~mode_sel;
    mode_wr   <= go;
    dly_q     <= mode_wr;
    sleep_req <= slow ? dly_q : mode_wr;
  end
endmodule
`default_nettype wire

// ==== tb/smcg_sleep_ctrl_tb.sv ====
`default_nettype none
module smcg_sleep_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        core_clk = 1'b0, sys_rst = 1'b1, sleep_en = 1'b1, go = 1'b0, slow = 1'b0;
  logic        irq_wake = 1'b0, hw_reset_wake = 1'b0, mode_wr, sleep_req, osc_en, cpu_run, asleep;
  logic [2:0]  mode = 3'h0, mode_sel, mode_q;
  logic [7:0]  clk_en, exp_q[$];
  logic [31:0] rs = 32'hFC90;
  int          err_count = 0, n_compared = 0;
  smcg_sleep_ctrl smcg_sleep_ctrl_i (
    .core_clk      (core_clk),
    .sys_rst       (sys_rst),
    .mode_sel      (mode_sel),
    .mode_wr       (mode_wr),
    .sleep_en      (sleep_en),
    .sleep_req     (sleep_req),
    .irq_wake      (irq_wake),
    .hw_reset_wake (hw_reset_wake),
    .clk_en        (clk_en),
    .osc_en        (osc_en),
    .cpu_run       (cpu_run),
    .asleep        (asleep),
    .mode_q        (mode_q)
  );
  smcg_cpu_model smcg_cpu_model_i (
    .core_clk  (core_clk),
    .go        (go),
    .slow      (slow),
    .mode      (mode),
    .mode_sel  (mode_sel),
    .mode_wr   (mode_wr),
    .sleep_req (sleep_req)
  );
  // 20 MHz clock
  always #25 core_clk = ~core_clk;
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    return v ^ (v << 5);
  endfunction
  task automatic check(input logic [7:0] seen, want);
    n_compared++;
    if (seen !== want) err_count++;
    if (seen !== want) $display("Error %0t: %h not %h", $time, seen, want);
  endtask
  task automatic give_verdict;
    $display("%0d errors in %0d checks", err_count, n_compared);
    if (err_count == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // one sleep per code, then two with sleep_en low; 4, 5 and those refused
  // wake source random
  task automatic run(input logic [2:0] m, input logic en);
    logic slp;
    slp = en && m[2:1] != 2'h2;
    rs = xs(rs);
    {go, mode, slow, sleep_en} <= {1'b1, m, rs[0], en};
    if (slp) exp_q.push_back({5'h0, m});
    @(posedge core_clk) go <= 1'b0;
    repeat (6) @(posedge core_clk);
    @(negedge core_clk) check({7'h0, asleep}, {7'h0, slp});
    check({7'h0, cpu_run}, {7'h0, !slp});
    // only power-down and power-save stop the oscillator
    check({7'h0, osc_en}, {7'h0, !(slp && m[2:1] == 2'h1)});
    @(posedge core_clk) {irq_wake, hw_reset_wake} <= {rs[1], !rs[1]};
    @(posedge core_clk) {irq_wake, hw_reset_wake} <= 2'h0;
    repeat (72) @(posedge core_clk);
    @(negedge core_clk) check(clk_en, 8'hFF);
    check({7'h0, cpu_run}, 8'h01);
    @(posedge core_clk);
  endtask
  // mode kept at sleep entry
  always @(posedge core_clk)
    if ($rose(asleep)) check({5'h0, mode_q}, exp_q.pop_front());
  initial begin
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 10; i++) run(i[2:0], i < 8);
    give_verdict;
  end
  // hang guard, well past the run length
  initial begin
    #100000;
    err_count++;
    give_verdict;
  end
endmodule
`default_nettype wire
